// file: rtl/ax25c_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Control octet goes out bit 0 first
// - I frame: bit0 zero, N(S), P/F, N(R)
// - S frame: bits 01, V(R) untouched
// - U frame: bits 11, modifier and P/F
// - S codes RR 00, RNR 01, REJ 10
// - Modulo-8 numbering, at most seven outstanding
// - V(S) fills N(S), advances after send
// - V(R) advances on in-sequence good I frame
// - N(R) loaded from V(R) before sending
// - Poll demands final reply, one outstanding
// - S frames only ever sent as responses
// - RR acknowledges and clears peer busy
// - RNR marks busy, stops I frame sending
// - UA, RR, REJ, SABM clear local busy
// - REJ restarts sending from N(R)
// - Single reject condition, cleared on recovery
// - SABM and DISC command codes
// - DM and UA response codes
// - FRMR and UI codes
// - SABM connects, DISC ends the session
// - Disconnected: answer commands with DM, F=1
// - U command acted on after UA sent
// - Bad or FCS-failed frames silently ignored
// - Out-of-sequence I info dropped, control used
module ax25c_engine
	import ax25c_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic tx_bit_o,
	output logic tx_valid_o,
	output logic tx_cmd_o,
	output logic info_ok_o,
	output logic info_drop_o,
	output logic connected_o
);
	ax25c_st_t st, next_st;
	ax25c_act_t act, next_act, rp_act, next_rp_act;
	ax25c_kind_t reply_k, next_rk;
	logic [2:0] vs, vr, va, next_vs, next_vr, next_va;
	logic lbusy, pbusy, rej, poll, reply_pend, reply_f, inf_i;
	logic next_lb, next_pb, next_rej, next_poll, next_rp, next_rf;
	logic next_infi;
	logic [EV_W-1:0] ev;
	logic [7:0] txo;
	logic ser_busy, ser_done;
	function automatic logic [7:0] build(input ax25c_kind_t k,
			input logic p, input logic [2:0] s, input logic [2:0] r);
		case (k)
			K_I: build = {r, p, s, 1'b0};
			K_RR: build = {r, p, S_RR, S_TAG};
			K_RNR: build = {r, p, S_RNR, S_TAG};
			K_REJ: build = {r, p, S_REJ, S_TAG};
			K_SABM: build = {U_SABM[7:5], p, U_SABM[3:0]};
			K_DISC: build = {U_DISC[7:5], p, U_DISC[3:0]};
			K_DM: build = {U_DM[7:5], p, U_DM[3:0]};
			K_UA: build = {U_UA[7:5], p, U_UA[3:0]};
			K_FRMR: build = {U_FRMR[7:5], p, U_FRMR[3:0]};
			default: build = {U_UI[7:5], p, U_UI[3:0]};
		endcase
	endfunction
	// Bus decode
	wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = acc & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
	wire wr_cmd = wr & (wb_adr_i == A_CMD);
	wire wr_rx = wr & (wb_adr_i == A_RX);
	wire wr_ev = wr & (wb_adr_i == A_EV);
	wire conn = st == ST_CONN;
	wire [2:0] outst = 3'(vs - va);
	// Software transmit request
	wire sw_go = wr_cmd & wb_dat_i[F_GO];
	ax25c_kind_t kind;
	assign kind = ax25c_kind_t'(wb_dat_i[3:0]);
	wire pfw = wb_dat_i[F_PF];
	wire ui_cmd = wb_dat_i[F_UICMD];
	wire is_sk = kind == K_RR || kind == K_RNR || kind == K_REJ;
	wire sw_cmdf = kind == K_I || kind == K_SABM || kind == K_DISC
		|| (kind == K_UI && ui_cmd);
	// Only one poll may be outstanding; a second poll bit is stripped
	wire sw_poll = pfw & sw_cmdf & ~poll;
	wire sw_pf = sw_cmdf ? sw_poll : pfw;
	wire i_bad = kind == K_I
		&& (!conn || pbusy || outst == WIN_MAX);
	wire k_bad = kind > K_FRMR || (is_sk && !conn)
		|| (kind == K_REJ && rej);
	wire sw_ref = ser_busy | reply_pend | i_bad | k_bad;
	wire ld_sw = sw_go & ~sw_ref;
	wire ld_reply = reply_pend & ~ser_busy;
	wire ld_any = ld_sw | ld_reply;
	ax25c_tx_t tx_d;
	// S frames always leave as responses
	assign tx_d = ld_reply ? {1'b0, build(reply_k, reply_f, vs, vr)}
		: {sw_cmdf, build(kind, sw_pf, vs, vr)};
	// Received control octet decode
	ax25c_rx_t rx;
	assign rx = ax25c_rx_t'(wb_dat_i[F_RX_W-1:0]);
	wire [7:0] u = rx.oct & U_MASK;
	wire pbit = rx.oct[F_PF];
	wire [2:0] nr = rx.oct[7:5];
	wire [2:0] ns = rx.oct[3:1];
	wire [1:0] sf = rx.oct[3:2];
	wire is_i = ~rx.oct[0];
	wire is_s = rx.oct[1:0] == S_TAG && sf != S_BAD;
	wire is_u = rx.oct[1:0] == 2'b11 && (u == U_SABM || u == U_DISC
		|| u == U_DM || u == U_UA || u == U_FRMR || u == U_UI);
	wire rx_ok = wr_rx & rx.fcs_ok & (is_i | is_s | is_u);
	// A reply still waiting to go out blocks new frames
	wire rx_take = rx_ok & ~reply_pend;
	wire rx_sabm = is_u && u == U_SABM && rx.is_cmd;
	wire i_seq = rx_take && conn && is_i && ns == vr;
	wire i_oos = rx_take && conn && is_i && ns != vr;
	always_comb begin
		next_st = st;
		next_act = act;
		next_vs = vs;
		next_vr = vr;
		next_va = va;
		next_lb = lbusy;
		next_pb = pbusy;
		next_rej = rej;
		next_poll = poll;
		next_rp = reply_pend;
		next_rk = reply_k;
		next_rf = reply_f;
		next_rp_act = rp_act;
		next_infi = inf_i;
		if (ser_done) begin
			if (inf_i) begin
				next_vs = 3'(vs + 3'h1);
			end
			// UA has left: only now does the received command take hold
			if (act == ACT_UP) begin
				next_st = ST_CONN;
				next_vs = SEQ_RST;
				next_vr = SEQ_RST;
				next_va = SEQ_RST;
				next_pb = 1'b0;
				next_rej = 1'b0;
			end else if (act == ACT_DOWN) begin
				next_st = ST_DISC;
			end
			next_act = ACT_NONE;
			next_infi = 1'b0;
		end
		if (ld_reply) begin
			next_rp = 1'b0;
			next_act = rp_act;
			next_infi = 1'b0;
			if (reply_k == K_RR || reply_k == K_UA) begin
				next_lb = 1'b0;
			end
		end
		if (ld_sw) begin
			next_infi = kind == K_I;
			next_act = ACT_NONE;
			if (sw_poll) begin
				next_poll = 1'b1;
			end
			case (kind)
				K_SABM: begin
					next_st = ST_CWAIT;
					next_lb = 1'b0;
				end
				K_DISC: next_st = ST_DWAIT;
				K_RR: next_lb = 1'b0;
				K_RNR: next_lb = 1'b1;
				K_REJ: begin
					next_lb = 1'b0;
					next_rej = 1'b1;
				end
				default: ;
			endcase
		end
		if (rx_take) begin
			if (!rx.is_cmd && pbit) begin
				next_poll = 1'b0;
			end
			if (rx_sabm) begin
				next_rp = 1'b1;
				next_rk = K_UA;
				next_rf = pbit;
				next_rp_act = ACT_UP;
			end else if (rx.is_cmd && !conn) begin
				next_rp = 1'b1;
				if (st == ST_DWAIT && is_u && u == U_DISC) begin
					next_rk = K_UA;
					next_rf = pbit;
					next_rp_act = ACT_DOWN;
				end else begin
					next_rk = K_DM;
					next_rf = 1'b1;
					next_rp_act = ACT_NONE;
				end
			end else if (!conn) begin
				if (is_u && u == U_UA && st == ST_CWAIT) begin
					next_st = ST_CONN;
					next_vs = SEQ_RST;
					next_vr = SEQ_RST;
					next_va = SEQ_RST;
					next_pb = 1'b0;
					next_rej = 1'b0;
				end else if (is_u && (u == U_UA || u == U_DM)
						&& st != ST_DISC) begin
					next_st = ST_DISC;
				end
			end else if (is_u && u == U_DISC && rx.is_cmd) begin
				next_rp = 1'b1;
				next_rk = K_UA;
				next_rf = pbit;
				next_rp_act = ACT_DOWN;
			end else if (is_u && u == U_DM) begin
				next_st = ST_DISC;
			end else if (is_i || is_s) begin
				next_va = nr;
				if (i_seq) begin
					next_vr = 3'(vr + 3'h1);
					next_rej = 1'b0;
				end
				if (is_s) begin
					next_pb = sf == S_RNR;
					if (sf == S_REJ) begin
						next_vs = nr;
					end
				end
				if (rx.is_cmd && pbit) begin
					next_rp = 1'b1;
					next_rk = lbusy ? K_RNR : K_RR;
					next_rf = 1'b1;
					next_rp_act = ACT_NONE;
				end
			end
		end
	end
	// Read mux; unmapped reads answer zero
	wire [31:0] stat = {10'h0, ser_busy, reply_pend, poll, rej, pbusy,
		lbusy, outst, st, va, vr, vs};
	wire [31:0] rd = wb_adr_i == A_STAT ? stat
		: wb_adr_i == A_TXO ? {23'h0, tx_cmd_o, txo}
		: wb_adr_i == A_EV ? {28'h0, ev} : 32'h0;
	// Event set beats a same-cycle write-one clear
	// A failed or invalid frame leaves no trace, not even an event
	wire [EV_W-1:0] ev_set = {rx_ok & ~rx_take, sw_go & sw_ref,
		i_oos, i_seq};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= ST_DISC;
			act <= ACT_NONE;
			vs <= SEQ_RST;
			vr <= SEQ_RST;
			va <= SEQ_RST;
			{lbusy, pbusy, rej, poll, reply_pend, reply_f} <= 6'h0;
			reply_k <= K_RR;
			rp_act <= ACT_NONE;
			inf_i <= 1'b0;
		end else begin
			st <= next_st;
			act <= next_act;
			vs <= next_vs;
			vr <= next_vr;
			va <= next_va;
			{lbusy, pbusy, rej, poll} <= {next_lb, next_pb, next_rej,
				next_poll};
			{reply_pend, reply_f} <= {next_rp, next_rf};
			reply_k <= next_rk;
			rp_act <= next_rp_act;
			inf_i <= next_infi;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ev <= '0;
			txo <= 8'h0;
			{info_ok_o, info_drop_o, connected_o} <= 3'h0;
		end else begin
			wb_ack_o <= acc;
			if (acc && !wb_we_i) begin
				wb_dat_o <= rd;
			end
			ev <= (ev & ~(wr_ev ? wb_dat_i[EV_W-1:0] : '0)) | ev_set;
			if (ld_any) begin
				txo <= tx_d.oct;
			end
			info_ok_o <= i_seq;
			info_drop_o <= i_oos;
			connected_o <= next_st == ST_CONN;
		end
	end
	ax25c_ser #(
		.W(OCT_W)
	) u_ser (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(ld_any),
		.din_i(tx_d),
		.bit_o(tx_bit_o),
		.valid_o(tx_valid_o),
		.cmd_o(tx_cmd_o),
		.busy_o(ser_busy),
		.done_o(ser_done)
	);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_vr_adv;
		i_seq |=> vr == 3'($past(vr) + 3'h1);
	endproperty
	a_vr_adv: assert property (p_vr_adv) else $error("vr not advanced");
	property p_s_hold;
		rx_take && conn && is_s && !ser_busy |=> $stable(vr);
	endproperty
	a_s_hold: assert property (p_s_hold) else $error("S frame moved vr");
	property p_busy;
		pbusy |-> !(ld_sw && kind == K_I);
	endproperty
	a_busy: assert property (p_busy) else $error("I sent while busy");
	property p_dm;
		rx_take && st == ST_DISC && rx.is_cmd && !rx_sabm
			|=> reply_pend && reply_k == K_DM && reply_f;
	endproperty
	a_dm: assert property (p_dm) else $error("no DM reply");
	property p_win;
		ld_sw && kind == K_I |-> outst != WIN_MAX;
	endproperty
	a_win: assert property (p_win) else $error("window overrun");
	property p_nr;
		ld_sw && kind == K_I |-> ##6 tx_bit_o == $past(vr[0], 6);
	endproperty
	a_nr: assert property (p_nr) else $error("N(R) not from vr");
	property p_s_resp;
		ld_any && tx_d.oct[1:0] == S_TAG |=> !tx_cmd_o && tx_valid_o;
	endproperty
	a_s_resp: assert property (p_s_resp) else $error("S as command");
	property p_up;
		ser_done && act == ACT_UP |=> conn && vs == SEQ_RST;
	endproperty
	a_up: assert property (p_up) else $error("UA not acted on");
	property p_vs_adv;
		ser_done && inf_i && !rx_take |=> vs == 3'($past(vs) + 3'h1);
	endproperty
	a_vs_adv: assert property (p_vs_adv) else $error("vs not advanced");
	property p_lb;
		ld_sw && kind == K_RR |=> !lbusy;
	endproperty
	a_lb: assert property (p_lb) else $error("busy not cleared");
	property p_drop;
		wr_rx && !rx.fcs_ok && !ser_busy |=> $stable(vr) && $stable(st);
	endproperty
	a_drop: assert property (p_drop) else $error("bad frame acted on");
	property p_rst;
		$past(rst_i) |-> st == ST_DISC && vs == SEQ_RST && !poll;
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
`default_nettype wire

// file: rtl/ax25c_pkg.sv
package ax25c_pkg;
	localparam int OCT_W = 8;
	localparam logic [4:0] A_CMD = 5'h00;
	localparam logic [4:0] A_RX = 5'h04;
	localparam logic [4:0] A_STAT = 5'h08;
	localparam logic [4:0] A_TXO = 5'h0c;
	localparam logic [4:0] A_EV = 5'h10;
	localparam int F_PF = 4;
	localparam int F_UICMD = 5;
	localparam int F_GO = 8;
	localparam int F_RX_W = 10;
	localparam int EV_W = 4;
	localparam logic [2:0] SEQ_RST = 3'h0;
	localparam logic [2:0] WIN_MAX = 3'h7;
	localparam logic [1:0] S_TAG = 2'h1;
	localparam logic [1:0] S_RR = 2'h0;
	localparam logic [1:0] S_RNR = 2'h1;
	localparam logic [1:0] S_REJ = 2'h2;
	localparam logic [1:0] S_BAD = 2'h3;
	localparam logic [7:0] U_MASK = 8'hef;
	localparam logic [7:0] U_SABM = 8'h2f;
	localparam logic [7:0] U_DISC = 8'h43;
	localparam logic [7:0] U_DM = 8'h0f;
	localparam logic [7:0] U_UA = 8'h63;
	localparam logic [7:0] U_FRMR = 8'h87;
	localparam logic [7:0] U_UI = 8'h03;
	typedef enum logic [3:0] {
		K_I = 4'h0, K_RR = 4'h1, K_RNR = 4'h2, K_REJ = 4'h3,
		K_SABM = 4'h4, K_DISC = 4'h5, K_UI = 4'h6, K_FRMR = 4'h7,
		K_DM = 4'h8, K_UA = 4'h9
	} ax25c_kind_t;
	typedef enum logic [3:0] {
		ST_DISC = 4'b0001, ST_CWAIT = 4'b0010,
		ST_CONN = 4'b0100, ST_DWAIT = 4'b1000
	} ax25c_st_t;
	typedef enum logic [1:0] {
		ACT_NONE = 2'h0, ACT_UP = 2'h1, ACT_DOWN = 2'h2
	} ax25c_act_t;
	typedef struct packed {
		logic cmd;
		logic [7:0] oct;
	} ax25c_tx_t;
	typedef struct packed {
		logic is_cmd;
		logic fcs_ok;
		logic [7:0] oct;
	} ax25c_rx_t;
endpackage

// file: rtl/ax25c_ser.sv
`timescale 1ns/1ps
`default_nettype none
module ax25c_ser
	import ax25c_pkg::*;
#(
	parameter int W = OCT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire ax25c_tx_t din_i,
	output logic bit_o,
	output logic valid_o,
	output logic cmd_o,
	output logic busy_o,
	output logic done_o
);
	if (W != OCT_W) begin : g_chk
		$error("ax25c_ser: W must equal the octet width");
	end
	logic [W-1:0] sh;
	logic [4:0] cnt;
	assign bit_o = sh[0];
	assign valid_o = cnt != 5'h0;
	// Done cycle counts as busy so the engine sees settled sequence state
	assign busy_o = valid_o | done_o;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh <= '0;
			cnt <= 5'h0;
			cmd_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i && !busy_o) begin
				sh <= din_i.oct;
				cnt <= 5'(W);
				cmd_o <= din_i.cmd;
			end else if (valid_o) begin
				sh <= sh >> 1;
				cnt <= cnt - 5'h1;
				done_o <= cnt == 5'h1;
			end
		end
	end
	property p_lsb;
		@(posedge clk_i) disable iff (rst_i)
		load_i && !busy_o |=> valid_o && bit_o == $past(din_i.oct[0])
			##7 bit_o == $past(din_i.oct[7], 8);
	endproperty
	a_lsb: assert property (p_lsb) else $error("octet not sent lsb first");
endmodule
`default_nettype wire

// file: tb/ax25c_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ax25c_engine_tb_top
	import ax25c_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [4:0] adr = 5'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] rd, wdo;
	logic ack, tbit, tval, tcmd, iok, idrop, conn, got, pcmd;
	logic [7:0] poct;
	logic sok = 1'b0;
	logic sdrop = 1'b0;
	int miscompares = 0;
	int comparisons = 0;
	int ngot = 0;
	int n0;
	always #4 clk_i = ~clk_i;
	ax25c_engine uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack), .tx_bit_o(tbit),
		.tx_valid_o(tval), .tx_cmd_o(tcmd), .info_ok_o(iok),
		.info_drop_o(idrop), .connected_o(conn));
	ax25c_peer peer (.clk_i(clk_i), .rst_i(rst_i), .bit_i(tbit),
		.valid_i(tval), .cmd_i(tcmd), .oct_o(poct), .cmd_o(pcmd),
		.got_o(got));
	// Pulses are caught here so a check need not hit their exact cycle
	always @(posedge clk_i) begin
		if (iok === 1'b1)
			sok <= 1'b1;
		if (idrop === 1'b1)
			sdrop <= 1'b1;
		if (got === 1'b1)
			ngot <= ngot + 1;
	end
	task automatic test_done;
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
			chk(32'h0, 32'h1);
	endtask
	task automatic cmd(input logic [3:0] k, input logic p, input logic u);
		wb(1'b1, A_CMD, {23'h0, 1'b1, 2'b00, u, p, k});
	endtask
	task automatic rx(input logic [7:0] o, input logic f, input logic c);
		wb(1'b1, A_RX, {22'h0, c, f, o});
	endtask
	task automatic rdst;
		wb(1'b0, A_STAT, 32'h0);
	endtask
	task automatic get(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (got !== 1'b1 && n < 100);
		if (n >= 100)
			chk(32'h0, 32'h1);
		chk({24'h0, poct}, {24'h0, e});
		repeat (2) @(posedge clk_i);
	endtask
	// Refusal must both flag the event and keep the line silent
	task automatic refused(input logic [3:0] k);
		wb(1'b1, A_EV, 32'hf);
		n0 = ngot;
		cmd(k, 1'b0, 1'b0);
		wb(1'b0, A_EV, 32'h0);
		chk(rd[2], 1'b1);
		repeat (14) @(posedge clk_i);
		chk(ngot, n0);
	endtask
	task automatic t_reset;
		rdst;
		chk(rd[21:0], 22'h200);
		chk(conn, 1'b0);
	endtask
	task automatic t_disc_mode;
		rx(U_DISC | 8'h10, 1'b1, 1'b1);
		get(U_DM | 8'h10);
		chk(pcmd, 1'b0);
		n0 = ngot;
		rx(U_SABM | 8'h10, 1'b0, 1'b1);
		repeat (20) @(posedge clk_i);
		chk(ngot, n0);
		rdst;
		chk(rd[12:9], 4'h1);
	endtask
	task automatic t_connect;
		rx(U_SABM | 8'h10, 1'b1, 1'b1);
		get(U_UA | 8'h10);
		repeat (2) @(posedge clk_i);
		chk(conn, 1'b1);
		rdst;
		chk(rd[12:9], 4'h4);
	endtask
	task automatic t_isend;
		for (int i = 0; i < 7; i++) begin
			cmd(4'h0, 1'b0, 1'b0);
			get({4'h0, 3'(i), 1'b0});
		end
		rdst;
		chk({rd[15:13], rd[2:0]}, 6'o77);
		refused(4'h0);
	endtask
	task automatic t_irx;
		rx(8'hf0, 1'b1, 1'b1);
		get(8'h31);
		chk(pcmd, 1'b0);
		chk(sok, 1'b1);
		rdst;
		chk({rd[15:13], rd[8:3]}, 9'o071);
		rx(8'he6, 1'b1, 1'b1);
		repeat (3) @(posedge clk_i);
		chk(sdrop, 1'b1);
		rdst;
		chk(rd[5:3], 3'h1);
	endtask
	task automatic t_sup;
		cmd(4'h2, 1'b0, 1'b0);
		get(8'h25);
		rdst;
		chk(rd[16], 1'b1);
		cmd(4'h1, 1'b0, 1'b0);
		get(8'h21);
		rdst;
		chk(rd[16], 1'b0);
		cmd(4'h3, 1'b0, 1'b0);
		get(8'h29);
		chk(pcmd, 1'b0);
		rdst;
		chk({rd[18], rd[5:0]}, 7'o117);
	endtask
	task automatic t_peer;
		rx(8'he5, 1'b1, 1'b0);
		rdst;
		chk(rd[17], 1'b1);
		refused(4'h0);
		rx(8'he1, 1'b1, 1'b0);
		rdst;
		chk(rd[17], 1'b0);
	endtask
	task automatic t_unnum;
		cmd(4'h6, 1'b0, 1'b1);
		get(U_UI);
		chk(pcmd, 1'b1);
		cmd(4'h7, 1'b1, 1'b0);
		get(U_FRMR | 8'h10);
		cmd(4'h5, 1'b1, 1'b0);
		get(U_DISC | 8'h10);
		chk(pcmd, 1'b1);
		rx(U_UA | 8'h10, 1'b1, 1'b0);
		repeat (2) @(posedge clk_i);
		chk(conn, 1'b0);
		cmd(4'h4, 1'b1, 1'b0);
		get(U_SABM | 8'h10);
		rx(U_UA | 8'h10, 1'b1, 1'b0);
		repeat (2) @(posedge clk_i);
		chk(conn, 1'b1);
	endtask
	// Second poll is stripped, peer REJ rewinds, DISC drops the link
	task automatic t_recover;
		cmd(4'h0, 1'b1, 1'b0);
		get(8'h10);
		cmd(4'h0, 1'b1, 1'b0);
		get(8'h02);
		rx(8'h19, 1'b1, 1'b0);
		rdst;
		chk(rd[2:0], 3'h0);
		chk(rd[19], 1'b0);
		rx(U_DISC | 8'h10, 1'b1, 1'b1);
		get(U_UA | 8'h10);
		chk(pcmd, 1'b0);
		repeat (2) @(posedge clk_i);
		chk(conn, 1'b0);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_disc_mode;
		t_connect;
		t_isend;
		t_irx;
		t_sup;
		t_peer;
		t_unnum;
		t_recover;
		test_done;
	end
	// Whole run is well under a thousand cycles; the 12500-cycle limit leaves wide margin
	initial begin
		#100000;
		miscompares++;
		test_done;
	end
endmodule
`default_nettype wire

// file: tb/ax25c_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ax25c_peer
	import ax25c_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bit_i,
	input wire logic valid_i,
	input wire logic cmd_i,
	output logic [7:0] oct_o,
	output logic cmd_o,
	output logic got_o
);
	logic [3:0] cnt;
	// Octet is only reported whole, so a short burst never shows up
	always_ff @(posedge clk_i) begin
		got_o <= 1'b0;
		if (rst_i) begin
			cnt <= 4'h0;
			oct_o <= 8'h00;
			cmd_o <= 1'b0;
		end else if (valid_i) begin
			oct_o <= {bit_i, oct_o[7:1]};
			cnt <= cnt + 4'h1;
			if (cnt == 4'h7) begin
				got_o <= 1'b1;
				cmd_o <= cmd_i;
				cnt <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire
